// ===== rtl/fsr_floppy_cmd.sv
// Command interpreter for floppy setup, version, status sense and relative seek.
//
// Summary of operation
// - Drive status sense returns status three immediately.
// - Head unload delay code times sixteen, zero maximum.
// - Step interval sixteen minus code milliseconds.
// - First step gap may be shorter.
// - Head load delay code times two, zero maximum; the code only stores it, and headLoad rises at once.
// - Delays scale with data rate, FM equals MFM.
// - dma_bypass one selects non-DMA mode.
// - DMA request or request_for_master plus interrupt.
// - implied_seek_enable stored for read/write seeking.
// - fifo_disable default one, byte transfers.
// - Polling enabled gives one interrupt after reset.
// - Polling suspended while head loaded.
// - fifo_threshold zero means one byte.
// - precomp_start_track stored, default track zero.
// - Version query returns fixed enhanced identifier.
// - Relative seek bit one steps inward.
// - Relative seek steps exact count, no compare.
// - Outward seek stopped at track zero sets equipment check in st0.
// - present_cylinder wraps modulo 256.
// - Recalibrate uses track zero, max 80 steps.
// - Commands use present_cylinder, no extended memory.
// - Interrupt raised at end of relative seek.
`timescale 1ns/1ps
`include "fsr_defs.svh"
module fsr_floppy_cmd
  import fsr_pkg::*;
#(
  parameter logic [7:0] VERSION_ID = 8'h5a,  // Arbitrary identifier value.
  parameter int         UNIT_CYC   = `FSR_UNIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  dataRate,
  input  wire logic        trackZeroSense,
  input  wire logic        writeProtect,
  input  wire logic        xferNeeded,
  output logic             stepPulse,
  output logic             stepInward,
  output logic             headLoad,
  output logic             dmaRequest,
  output logic             intRequest
);
  initial begin
    if (UNIT_CYC < 1 || UNIT_CYC > 65535) $error("UNIT_CYC out of range");
  end

  // Register map seen by the host, in the low end of each word, one byte each, two for CFG and TIMING:
  //   FIFO    command and parameter bytes in, result bytes out.
  //   STATUS  bit 7 ready for a byte, bit 6 a result byte waits.
  //   CTRL    last interrupt status byte, kept for diagnosis.
  //   CYL     present_cylinder as the stepper left it.
  //   CFG     precompensation track and feature bits of the configure command.
  //   TIMING  head load, transfer mode, step rate and head unload codes.
  // Only one relative seek runs at a time; the host must close it with an
  // interrupt status sense before the next command that moves the head.
  // Bytes written while the stepper runs are dropped, so the host polls first.

  fsr_state_e  state;
  logic [7:0]  cmdBuf [0:3];
  logic [1:0]  cmdCnt, cmdNeed;
  logic [7:0]  resByte;
  logic [3:0]  headUnloadTime, stepRateTime, fifoThreshold;
  logic [6:0]  headLoadTime;
  logic        dmaBypass, impliedSeekEnable, fifoDisable, driveScanDisable;
  logic [7:0]  precompStartTrack, presentCylinder, stepsLeft, st0;
  logic [15:0] unitCnt;
  logic [9:0]  delayUnits;
  logic        unitTick, firstStep, isRecal, pollPending, unloadBusy;
  logic [1:0]  tz0, tz1;
  logic [11:0] unloadUnits;
  logic        wrFifo, rdFifo;
  logic        resMore;
  logic [9:0]  stepGap;
  logic [7:0]  statusByte, driveStatus;

  assign wrFifo = psel & penable & pwrite & (paddr == `FSR_OFF_FIFO);
  assign rdFifo = psel & penable & ~pwrite & (paddr == `FSR_OFF_FIFO);
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Main status byte: ready whenever a byte may move, result flag in the result phase.
  assign statusByte = {(state == FSR_IDLE) || (state == FSR_CMD) || (state == FSR_RES),
                       state == FSR_RES, 6'h00};
  // Drive status: write protect, ready, track zero, two sides, head and unit select.
  assign driveStatus = {1'b0, tz1[1], 1'b1, tz1[0], 1'b1, cmdBuf[1][2:0]};

  // Two-flop synchronisers on drive pins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tz0 <= 2'b00;
      tz1 <= 2'b00;
    end else begin
      tz0 <= {writeProtect, trackZeroSense};
      tz1 <= tz0;
    end
  end

  // Base tick of 0.5 ms at 500 kbps; slower rates lengthen, faster shorten it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unitCnt  <= 16'h0000;
      unitTick <= 1'b0;
    end else begin
      unitTick <= 1'b0;
      if (unitCnt == 16'h0000) begin
        unitTick <= 1'b1;
        case (dataRate)
          2'd0:    unitCnt <= 16'(UNIT_CYC - 1);
          2'd1:    unitCnt <= 16'((UNIT_CYC * 5) / 3 - 1);
          2'd2:    unitCnt <= 16'(UNIT_CYC * 2 - 1);
          default: unitCnt <= 16'(UNIT_CYC / 2 - 1);
        endcase
      end else begin
        unitCnt <= unitCnt - 16'h0001;
      end
    end
  end

  // Number of opcode parameter bytes.
  always_comb begin
    case (cmdBuf[0])
      `FSR_OP_SPECIFY:   cmdNeed = 2'd2;
      `FSR_OP_SENSEDRV:  cmdNeed = 2'd1;
      `FSR_OP_RECAL:     cmdNeed = 2'd1;
      `FSR_OP_SEEK:      cmdNeed = 2'd2;
      `FSR_OP_CONFIGURE: cmdNeed = 2'd3;
      default:           cmdNeed = (cmdBuf[0][6:0] == `FSR_OP_RELSEEK) ? 2'd2 : 2'd0;
    endcase
  end

  // Units to wait after a pulse: two half-millisecond units per millisecond of
  // step interval, sixteen minus the code; the gap after the first pulse is one
  // unit short, which the rules allow and which keeps the counter load simple.
  always_comb begin
    if (firstStep) begin
      stepGap = {4'd0, 6'd31 - {1'b0, stepRateTime, 1'b0}} - 10'd1;
    end else begin
      stepGap = {4'd0, 6'd32 - {1'b0, stepRateTime, 1'b0}} - 10'd1;
    end
  end

  // Main command sequencer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FSR_IDLE;
      cmdCnt <= 2'd0;
      cmdBuf[0] <= 8'h00;
      cmdBuf[1] <= 8'h00;
      cmdBuf[2] <= 8'h00;
      cmdBuf[3] <= 8'h00;
      resByte <= 8'h00;
      resMore <= 1'b0;
      headUnloadTime <= `FSR_RST_HUT;
      stepRateTime <= `FSR_RST_SRT;
      headLoadTime <= `FSR_RST_HLT;
      dmaBypass <= `FSR_RST_NODMA;
      impliedSeekEnable <= `FSR_RST_EIS;
      fifoDisable <= `FSR_RST_FIFODIS;
      driveScanDisable <= `FSR_RST_POLLDIS;
      fifoThreshold <= `FSR_RST_THR;
      precompStartTrack <= `FSR_RST_PRECOMP_START_TRACK;
      presentCylinder <= 8'h00;
      stepsLeft <= 8'h00;
      st0 <= 8'h00;
      delayUnits <= 10'd0;
      firstStep <= 1'b0;
      isRecal <= 1'b0;
      stepPulse <= 1'b0;
      stepInward <= 1'b0;
      intRequest <= 1'b0;
      pollPending <= 1'b1;
    end else begin
      stepPulse <= 1'b0;
      // One polling interrupt after reset, held off while the head stays loaded.
      if (pollPending && !driveScanDisable && !unloadBusy && state == FSR_IDLE) begin
        intRequest  <= 1'b1;
        st0         <= 8'hc0;
        pollPending <= 1'b0;
      end
      case (state)
        FSR_IDLE: begin
          if (wrFifo) begin
            cmdBuf[0] <= pwdata[7:0];
            cmdCnt <= 2'd0;
            state <= FSR_CMD;
          end
        end
        FSR_CMD: begin
          if (cmdCnt == cmdNeed) begin
            state <= FSR_RES;
            case (cmdBuf[0])
              `FSR_OP_SENSEDRV: resByte <= driveStatus;
              `FSR_OP_VERSION:  resByte <= VERSION_ID;
              `FSR_OP_SENSEINT: begin
                resByte <= st0;
                resMore <= 1'b1;
                intRequest <= 1'b0;
              end
              `FSR_OP_SPECIFY: begin
                stepRateTime <= cmdBuf[1][7:4];
                headUnloadTime <= cmdBuf[1][3:0];
                headLoadTime <= cmdBuf[2][7:1];
                dmaBypass <= cmdBuf[2][0];
                state <= FSR_IDLE;
              end
              `FSR_OP_CONFIGURE: begin
                impliedSeekEnable <= cmdBuf[2][6];
                fifoDisable <= cmdBuf[2][5];
                driveScanDisable <= cmdBuf[2][4];
                fifoThreshold <= cmdBuf[2][3:0];
                precompStartTrack <= cmdBuf[3];
                state <= FSR_IDLE;
              end
              `FSR_OP_RECAL: begin
                presentCylinder <= 8'h00;
                stepsLeft <= `FSR_RECAL_MAX;
                isRecal <= 1'b1;
                stepInward <= 1'b0;
                st0 <= 8'h00;
                firstStep <= 1'b1;
                state <= FSR_STEP;
              end
              default: begin
                if (cmdBuf[0][6:0] == `FSR_OP_RELSEEK) begin
                  stepInward <= cmdBuf[0][7];
                  stepsLeft <= cmdBuf[2];
                  isRecal <= 1'b0;
                  st0 <= 8'h00;
                  firstStep <= 1'b1;
                  state <= FSR_STEP;
                end else begin
                  resByte <= 8'h80;
                end
              end
            endcase
          end else if (wrFifo) begin
            cmdCnt <= cmdCnt + 2'd1;
            // Parameter bytes fill the buffer behind the opcode in arrival order.
            cmdBuf[cmdCnt + 2'd1] <= pwdata[7:0];
          end
        end
        FSR_STEP: begin
          if (isRecal && tz1[0]) begin
            st0[`FSR_SE_BIT] <= 1'b1;
            intRequest <= 1'b1;
            state <= FSR_IDLE;
          end else if (stepsLeft == 8'h00) begin
            st0[`FSR_SE_BIT] <= 1'b1;
            st0[`FSR_EC_BIT] <= isRecal;
            intRequest <= 1'b1;
            state <= FSR_IDLE;
          end else if (!isRecal && !stepInward && tz1[0]) begin
            st0[`FSR_EC_BIT] <= 1'b1;
            st0[`FSR_SE_BIT] <= 1'b1;
            intRequest <= 1'b1;
            state <= FSR_IDLE;
          end else begin
            stepPulse <= 1'b1;
            stepsLeft <= stepsLeft - 8'h01;
            if (!isRecal) begin
              presentCylinder <= stepInward ? presentCylinder + 8'h01
                                            : presentCylinder - 8'h01;
            end
            delayUnits <= stepGap;
            firstStep <= 1'b0;
            state <= FSR_WAIT;
          end
        end
        FSR_WAIT: begin
          if (unitTick) begin
            if (delayUnits == 10'd0) state <= FSR_STEP;
            else delayUnits <= delayUnits - 10'd1;
          end
        end
        FSR_RES: begin
          // The interrupt status sense answers with two bytes: status, then cylinder.
          if (rdFifo) begin
            if (resMore) begin
              resByte <= presentCylinder;
              resMore <= 1'b0;
            end else begin
              state <= FSR_IDLE;
            end
          end
        end
        default: state <= FSR_IDLE;
      endcase
      if (xferNeeded && dmaBypass) intRequest <= 1'b1;
    end
  end

  // Head load and unload timing.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      headLoad <= 1'b0;
      unloadUnits <= 12'd0;
    end else if (xferNeeded) begin
      headLoad <= 1'b1;
      // Code zero means the longest delay, 512 units.
      unloadUnits <= (headUnloadTime == 4'h0) ? 12'd512 : {3'd0, headUnloadTime, 5'd0};
    end else if (unitTick && unloadUnits != 12'd0) begin
      unloadUnits <= unloadUnits - 12'd1;
      if (unloadUnits == 12'd1) headLoad <= 1'b0;
    end
  end
  assign unloadBusy = headLoad;

  // Transfer signalling.
  assign dmaRequest = xferNeeded & ~dmaBypass;

  // Register reads.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `FSR_OFF_FIFO:   prdata <= {24'h0, resByte};
        `FSR_OFF_STATUS: prdata <= {24'h0, statusByte};
        `FSR_OFF_CTRL:   prdata <= {24'h0, st0};
        `FSR_OFF_CYL:    prdata <= {24'h0, presentCylinder};
        `FSR_OFF_CFG:    prdata <= {16'h0, precompStartTrack, 1'b0, impliedSeekEnable,
                                    fifoDisable, driveScanDisable, fifoThreshold};
        `FSR_OFF_TIMING: prdata <= {16'h0, headLoadTime, dmaBypass, stepRateTime,
                                    headUnloadTime};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end
  // Head load delay is stored for the transfer engine; code zero means maximum.
endmodule

// ===== rtl/fsr_defs.svh
// Offsets, field positions, reset values and timing counts for the floppy command block.
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH
`define FSR_OFF_FIFO      12'h000
`define FSR_OFF_STATUS    12'h004
`define FSR_OFF_CTRL      12'h008
`define FSR_OFF_CYL       12'h00c
`define FSR_OFF_CFG       12'h010
`define FSR_OFF_TIMING    12'h014
`define FSR_OP_SPECIFY    8'h03
`define FSR_OP_SENSEDRV   8'h04
`define FSR_OP_RECAL      8'h07
`define FSR_OP_SENSEINT   8'h08
`define FSR_OP_SEEK       8'h0f
`define FSR_OP_VERSION    8'h10
`define FSR_OP_CONFIGURE  8'h13
`define FSR_OP_RELSEEK    7'h47
`define FSR_RST_HUT       4'h0
`define FSR_RST_SRT       4'h0
`define FSR_RST_HLT       7'h00
`define FSR_RST_NODMA     1'b0
`define FSR_RST_EIS       1'b0
`define FSR_RST_FIFODIS   1'b1
`define FSR_RST_POLLDIS   1'b0
`define FSR_RST_THR       4'h0
`define FSR_RST_PRECOMP_START_TRACK    8'h00
`define FSR_RECAL_MAX     8'd80
`define FSR_EC_BIT        4
`define FSR_SE_BIT        5
`define FSR_CLK_HZ        25000000
`define FSR_UNIT_US       500
`define FSR_UNIT_CYC      ((`FSR_CLK_HZ / 1000000) * `FSR_UNIT_US)
`endif

// ===== rtl/fsr_pkg.sv
// Types shared by the floppy command block.
package fsr_pkg;
  typedef enum logic [2:0] {
    FSR_IDLE,
    FSR_CMD,
    FSR_STEP,
    FSR_WAIT,
    FSR_RES
  } fsr_state_e;
endpackage

// ===== bench/fsr_floppy_props.sv
// Port checker for the floppy command block.
`timescale 1ns/1ps
module fsr_floppy_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        xferNeeded,
  input wire logic        stepPulse,
  input wire logic        stepInward,
  input wire logic        dmaRequest,
  input wire logic        intRequest
);
  // All checks run on the block clock and rest during reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  bus_ready_a: assert property (psel |-> pready && !pslverr)
    else $error("bus answer not immediate");
  dma_gate_a: assert property (dmaRequest |-> xferNeeded)
    else $error("dma request without transfer need");
  step_space_a: assert property (stepPulse |=> !stepPulse [*8])
    else $error("step pulses too close");
  step_dir_a: assert property (stepPulse |=> $stable(stepInward))
    else $error("direction moved after a step");
  dir_hold_a: assert property ($changed(stepInward) |-> !stepPulse)
    else $error("direction changed on a step");
  poll_int_a: assert property ($rose(rst_n) |-> ##[0:3] intRequest)
    else $error("no interrupt after reset");
  int_drop_a: assert property ($fell(intRequest) |->
    $past(psel, 1) || $past(psel, 2) || $past(psel, 3) || $past(psel, 4))
    else $error("interrupt dropped without host access");
  rd_hold_a: assert property ($changed(prdata) |->
    $past(psel && !penable && !pwrite)) else $error("read data moved unasked");
endmodule
bind fsr_floppy_cmd fsr_floppy_props fsr_floppy_props_i (
  .clk, .rst_n, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .xferNeeded, .stepPulse, .stepInward, .dmaRequest, .intRequest);

// ===== bench/fsr_drive_model.sv
// Behavioural drive head that follows step pulses.
`timescale 1ns/1ps
module fsr_drive_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stepPulse,
  input wire logic stepInward,
  output logic     trackZeroSense,
  output int       track
);
  // The head moves one track a pulse and stops at the outer end.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      track <= 0;
    end else if (stepPulse) begin
      track <= stepInward ? track + 1 : (track > 0 ? track - 1 : 0);
    end
  end
  // Track zero is sensed from the physical head position only.
  assign trackZeroSense = (track == 0);
endmodule

// ===== bench/tb.sv
// Self-checking bench for the floppy command block.
`timescale 1ns/1ps
`include "fsr_defs.svh"
module tb;
  import fsr_pkg::*;
  localparam logic [7:0] VER = 8'h5a; // Arbitrary identifier value.
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        writeProtect = 1'b0, xferNeeded = 1'b0, trackZeroSense;
  logic        pready, pslverr, stepPulse, stepInward, headLoad, dmaRequest, intRequest;
  int          seed = 31618, mismatches = 0, tests_run = 0, pulses = 0;
  int          track, present_cylinder = 0, phys = 0, p0;

  fsr_floppy_cmd #(.VERSION_ID(VER), .UNIT_CYC(4)) fsr_floppy_cmd_i (.clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dataRate(2'h3),
    .trackZeroSense, .writeProtect, .xferNeeded, .stepPulse, .stepInward, .headLoad,
    .dmaRequest, .intRequest);
  fsr_drive_model fsr_drive_model_i (.clk, .rst_n, .stepPulse, .stepInward, .trackZeroSense,
    .track);

  // Clock, step counter and random write-protect level.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (stepPulse === 1'b1) pulses <= pulses + 1;
    writeProtect <= $random(seed);
  end

  task wrap_up;
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus transfer; read data lands in q.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin mismatches++; wrap_up; end
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  // Polls the status register until the given bit is set.
  task wait_st(input int b);
    int n;
    for (n = 0; n < 20000; n++) begin
      apb(1'b0, `FSR_OFF_STATUS, 32'h0);
      if (q[b] === 1'b1) break;
    end
    if (n == 20000) begin mismatches++; wrap_up; end
  endtask

  task put(input logic [7:0] b);
    wait_st(7);
    apb(1'b1, `FSR_OFF_FIFO, {24'h0, b});
  endtask

  task get;
    wait_st(6);
    apb(1'b0, `FSR_OFF_FIFO, 32'h0);
  endtask

  task spec(input logic nd);
    put(`FSR_OP_SPECIFY); put(8'h81); put({7'h01, nd});
    xferNeeded <= 1'b1;
    repeat (2) @(posedge clk);
    check("dma request", dmaRequest, !nd);
    check("transfer int", intRequest, nd);
    check("head load", headLoad, 1'b1);
    xferNeeded <= 1'b0;
    apb(1'b0, `FSR_OFF_TIMING, 32'h0);
    check("timing", q, {16'h0, 7'h01, nd, 8'h81});
  endtask

  // Relative seek, then the closing sense of its interrupt.
  task seek(input logic d, input int n, input logic fault);
    int w;
    p0 = pulses;
    put({d, `FSR_OP_RELSEEK}); put(8'h00); put(n[7:0]);
    for (w = 0; w < 40000 && intRequest !== 1'b1; w++) @(posedge clk);
    if (w == 40000) begin mismatches++; wrap_up; end
    repeat (2) @(posedge clk);
    put(`FSR_OP_SENSEINT); get;
    if (fault) begin
      check("outward fault", q[4], 1'b1);
      present_cylinder = (present_cylinder - phys + 256) % 256;
      get;
      check("fault cylinder", q[7:0], present_cylinder[7:0]);
      check("fault steps", pulses - p0, n - 1);
      phys = 0;
    end else begin
      check("seek st0", q[7:0], 8'h20);
      present_cylinder = d ? (present_cylinder + n) % 256 : (present_cylinder - n + 256) % 256;
      phys = d ? phys + n : phys - n;
      get; check("cylinder", q[7:0], present_cylinder[7:0]);
      check("steps", pulses - p0, n);
      check("direction", stepInward, d);
      check("head track", track, phys);
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("poll int", intRequest, 1'b1);
    put(`FSR_OP_SENSEINT); get; check("poll st0", q[7:0], 8'hc0);
    get; check("poll cyl", q[7:0], 8'h00);
    check("int cleared", intRequest, 1'b0);
    put(`FSR_OP_VERSION); get; check("version", q[7:0], VER);
    apb(1'b0, `FSR_OFF_CFG, 32'h0);
    check("config default", q, 32'h0000_0020);
    put(`FSR_OP_CONFIGURE); put(8'h00); put(8'h57); put(8'h2c);
    apb(1'b0, `FSR_OFF_CFG, 32'h0);
    check("config", q, 32'h0000_2c57);
    put(`FSR_OP_SENSEDRV); put(8'h00);
    apb(1'b0, `FSR_OFF_STATUS, 32'h0);
    check("no execution", q[6], 1'b1);
    get;
    check("drive status", {q[7], q[5:0]}, 7'h38);
    spec(1'b0);
    for (int k = 0; k < 4; k++) seek(1'b1, 1 + ($random(seed) & 31), 1'b0);
    seek(1'b1, 255, 1'b0);
    seek(1'b0, 255, 1'b0);
    seek(1'b0, phys + 1, 1'b1);
    spec(1'b1);
    wrap_up;
  end
endmodule
